// ### wcd_pkg.sv
// Purpose: Shared constants and carriers for the write command decoder
// Assumes: Command words arrive already gathered from a submission queue entry
// Notes: All field positions and status codes are named here
package wcd_pkg;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int WCD_LR_BIT = 31;
    localparam int WCD_FUA_BIT = 30;
    localparam int WCD_PI_HI = 29;
    localparam int WCD_PI_LO = 26;
    localparam int WCD_RSV12A_HI = 25;
    localparam int WCD_RSV12A_LO = 24;
    localparam int WCD_DT_HI = 23;
    localparam int WCD_DT_LO = 20;
    localparam int WCD_RSV12B_HI = 19;
    localparam int WCD_RSV12B_LO = 16;
    localparam int WCD_NLB_HI = 15;
    localparam int WCD_NLB_LO = 0;
    localparam int WCD_DV_HI = 31;
    localparam int WCD_DV_LO = 16;
    localparam int WCD_RSV13_HI = 15;
    localparam int WCD_RSV13_LO = 8;
    localparam int WCD_INCOMP_BIT = 7;
    localparam int WCD_SEQ_BIT = 6;
    localparam int WCD_LAT_HI = 5;
    localparam int WCD_LAT_LO = 4;
    localparam int WCD_FREQ_HI = 3;
    localparam int WCD_FREQ_LO = 0;
    localparam int WCD_TM_HI = 31;
    localparam int WCD_TM_LO = 16;
    localparam int WCD_TV_HI = 15;
    localparam int WCD_TV_LO = 0;

    // ************************************************************
    // Codes
    // ************************************************************
    localparam logic [3:0] WCD_FREQ_LAST = 4'h6;
    localparam logic [7:0] WCD_SC_SUCCESS = 8'h00;
    localparam logic [7:0] WCD_SC_CONFLICT = 8'h80;
    localparam logic [7:0] WCD_SC_BAD_PI = 8'h81;
    localparam logic [7:0] WCD_SC_READ_ONLY = 8'h82;
    localparam logic [16:0] WCD_ONE_17 = 17'h00001;

    typedef enum logic [1:0] {
        WCD_LAT_NONE = 2'h0,
        WCD_LAT_IDLE = 2'h1,
        WCD_LAT_NORMAL = 2'h2,
        WCD_LAT_LOW = 2'h3
    } wcd_latency_t;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic sgl_mode;
        logic [63:0] meta_buffer_pointer;
        logic [127:0] data_buffer_pointer;
        logic [31:0] dw10;
        logic [31:0] dw11;
        logic [31:0] dw12;
        logic [31:0] dw13;
        logic [31:0] dw14;
        logic [31:0] dw15;
    } wcd_cmd_t;

    typedef struct packed {
        logic incompressible;
        logic sequential;
        wcd_latency_t latency;
        logic [3:0] frequency;
        logic freq_reserved;
    } wcd_hints_t;

    typedef struct packed {
        logic sgl_mode;
        logic [63:0] meta_buffer_pointer;
        logic [63:0] prp_entry_1;
        logic [63:0] prp_entry_2;
        logic [127:0] sgl_entry_1;
        logic [63:0] first_block_address;
        logic [16:0] block_total;
        logic [15:0] block_count_minus_one;
        logic limited_retry;
        logic force_media_commit;
        logic [3:0] protection_action_check;
        logic [3:0] directive_kind;
        logic [15:0] directive_value;
        wcd_hints_t dataset_hints;
        logic pi_in_use;
        logic meta_in_use;
        logic [31:0] initial_reference_tag;
        logic [15:0] app_tag_mask;
        logic [15:0] app_tag_value;
    } wcd_job_t;

    typedef struct packed {
        logic [15:0] cmd_id;
        logic [7:0] status;
    } wcd_cpl_t;

endpackage

// ### wcd_hint_decode.sv
// Purpose: Decodes the dataset management hints byte
// Assumes: Byte taken from the low bits of command word thirteen
// Notes: Purely combinational
`timescale 1ns/1ps
module wcd_hint_decode
    import wcd_pkg::*;
(
    input wire logic [7:0] hint_byte,
    output wcd_hints_t hints
);

    // ************************************************************
    // Hint fields
    // ************************************************************
    always_comb begin
        hints.incompressible = hint_byte[WCD_INCOMP_BIT];
        hints.sequential = hint_byte[WCD_SEQ_BIT];
        hints.latency = wcd_latency_t'(hint_byte[WCD_LAT_HI:WCD_LAT_LO]);
        hints.frequency = hint_byte[WCD_FREQ_HI:WCD_FREQ_LO];
        hints.freq_reserved = hint_byte[WCD_FREQ_HI:WCD_FREQ_LO] > WCD_FREQ_LAST;
    end

endmodule

// ### wcd_skid.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: One clock, asynchronous active-low reset
// Notes: Ready upstream depends only on stored state
`timescale 1ns/1ps
module wcd_skid #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    if (WIDTH < 1) begin : g_bad_width
        $error("wcd_skid width must be positive");
    end

    logic [WIDTH-1:0] slot_ff [2];
    logic rd_ff;
    logic wr_ff;
    logic [1:0] cnt_ff;
    logic push;
    logic pop;

    assign push = in_valid && (cnt_ff != 2'h2);
    assign pop = out_valid && out_ready;
    assign in_ready = cnt_ff != 2'h2;
    assign out_valid = cnt_ff != 2'h0;
    assign out_data = slot_ff[rd_ff];

    // ************************************************************
    // Storage
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            slot_ff[0] <= '0;
            slot_ff[1] <= '0;
        end else if (push) begin
            slot_ff[wr_ff] <= in_data;
        end
    end

    // ************************************************************
    // Pointers and count
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            if (push) begin
                wr_ff <= ~wr_ff;
            end
            if (pop) begin
                rd_ff <= ~rd_ff;
            end
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule

// ### wcd_decoder.sv
// Purpose: Decodes a storage Write command into its fields and posts a completion
// Assumes: Namespace format and range protection given as plain inputs
// Notes: Decoded job leaves through a two-entry buffer; completion follows acceptance
`timescale 1ns/1ps

module wcd_decoder
    import wcd_pkg::*;
#(
    parameter int ID_WIDTH = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [ID_WIDTH-1:0] cmd_id,
    input wire wcd_cmd_t cmd,
    input wire logic ns_pi_enabled,
    input wire logic ns_meta_enabled,
    input wire logic [3:0] ns_pi_allowed_mask,
    input wire logic range_read_only,
    input wire logic directives_enabled,
    output logic job_valid,
    input wire logic job_ready,
    output wcd_job_t job,
    output logic cpl_valid,
    input wire logic cpl_ready,
    output wcd_cpl_t cpl
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (ID_WIDTH < 1 || ID_WIDTH > 16) begin : g_bad_id
        $error("wcd_decoder ID_WIDTH must be 1 to 16");
    end
    if (WCD_PI_HI - WCD_PI_LO != 3 || WCD_DT_HI - WCD_DT_LO != 3) begin : g_bad_nibble
        $error("wcd_decoder nibble fields must be four bits wide");
    end
    if (WCD_NLB_HI - WCD_NLB_LO != 15 || WCD_DV_HI - WCD_DV_LO != 15) begin : g_bad_half
        $error("wcd_decoder count and directive fields must be sixteen bits wide");
    end
    if (WCD_TM_HI - WCD_TM_LO != 15 || WCD_TV_HI - WCD_TV_LO != 15) begin : g_bad_tag
        $error("wcd_decoder tag fields must be sixteen bits wide");
    end
    if (WCD_INCOMP_BIT - WCD_FREQ_LO != 7) begin : g_bad_hint
        $error("wcd_decoder hint byte must be eight bits wide");
    end
    if (WCD_RSV12A_HI >= WCD_PI_LO || WCD_RSV12A_LO <= WCD_DT_HI) begin : g_bad_rsv12a
        $error("wcd_decoder reserved range overlaps a field");
    end
    if (WCD_RSV12B_HI >= WCD_DT_LO || WCD_RSV12B_LO <= WCD_NLB_HI) begin : g_bad_rsv12b
        $error("wcd_decoder reserved range overlaps a field");
    end
    if (WCD_RSV13_HI >= WCD_DV_LO || WCD_RSV13_LO <= WCD_INCOMP_BIT) begin : g_bad_rsv13
        $error("wcd_decoder reserved range overlaps a field");
    end

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic [3:0] nib(input logic [31:0] w, input int lo);
        nib = w[lo +: 4];
    endfunction

    function automatic logic [15:0] half(input logic [31:0] w, input int lo);
        half = w[lo +: 16];
    endfunction

    function automatic logic pi_illegal(
        input logic [3:0] pi,
        input logic pi_on,
        input logic [3:0] allowed
    );
        if (pi_on) begin
            pi_illegal = (pi & ~allowed) != 4'h0;
        end else begin
            pi_illegal = pi != 4'h0;
        end
    endfunction

    function automatic logic [15:0] gate16(input logic on, input logic [15:0] v);
        gate16 = on ? v : 16'h0000;
    endfunction

    // ************************************************************
    // Signals
    // ************************************************************
    wcd_hints_t hints;
    wcd_job_t dec;
    logic [63:0] meta_ptr;
    logic [63:0] prp_1;
    logic [63:0] prp_2;
    logic [127:0] sgl_1;
    logic [31:0] ref_tag;
    logic [15:0] tag_mask;
    logic [15:0] tag_value;
    logic [3:0] pi_field;
    logic [3:0] dt_field;
    logic [15:0] nlb_field;
    logic [7:0] status;
    logic pi_bad;
    logic conflict;
    logic ok;
    logic take;
    logic buf_in_ready;
    logic out_valid;
    logic out_ready;
    logic nxt_cmd_ready;
    wcd_job_t out_job;

    // ************************************************************
    // Hints
    // ************************************************************
    wcd_hint_decode u_hints (
        .hint_byte(cmd.dw13[WCD_INCOMP_BIT:WCD_FREQ_LO]),
        .hints(hints)
    );

    // ************************************************************
    // Field extraction
    // ************************************************************
    assign pi_field = nib(cmd.dw12, WCD_PI_LO);
    assign dt_field = nib(cmd.dw12, WCD_DT_LO);
    assign nlb_field = half(cmd.dw12, WCD_NLB_LO);

    // ************************************************************
    // Pointer selection
    // ************************************************************
    always_comb begin
        meta_ptr = '0;
        prp_1 = '0;
        prp_2 = '0;
        sgl_1 = '0;
        if (ns_meta_enabled) begin
            meta_ptr = cmd.meta_buffer_pointer;
        end
        if (cmd.sgl_mode) begin
            sgl_1 = cmd.data_buffer_pointer;
        end else begin
            prp_1 = cmd.data_buffer_pointer[63:0];
            prp_2 = cmd.data_buffer_pointer[127:64];
        end
    end

    // ************************************************************
    // Protection tags
    // ************************************************************
    assign ref_tag = ns_pi_enabled ? cmd.dw14 : '0;
    assign tag_mask = gate16(ns_pi_enabled, half(cmd.dw15, WCD_TM_LO));
    assign tag_value = gate16(ns_pi_enabled, half(cmd.dw15, WCD_TV_LO));

    // ************************************************************
    // Job assembly
    // ************************************************************
    always_comb begin
        dec = '0;
        dec.sgl_mode = cmd.sgl_mode;
        dec.meta_in_use = ns_meta_enabled;
        dec.pi_in_use = ns_pi_enabled;
        dec.meta_buffer_pointer = meta_ptr;
        dec.prp_entry_1 = prp_1;
        dec.prp_entry_2 = prp_2;
        dec.sgl_entry_1 = sgl_1;
        dec.first_block_address = {cmd.dw11, cmd.dw10};
        dec.limited_retry = cmd.dw12[WCD_LR_BIT];
        dec.force_media_commit = cmd.dw12[WCD_FUA_BIT];
        dec.protection_action_check = pi_field;
        dec.directive_kind = dt_field;
        dec.block_count_minus_one = nlb_field;
        dec.block_total = {1'b0, nlb_field} + WCD_ONE_17;
        dec.directive_value = half(cmd.dw13, WCD_DV_LO);
        dec.dataset_hints = hints;
        dec.initial_reference_tag = ref_tag;
        dec.app_tag_mask = tag_mask;
        dec.app_tag_value = tag_value;
    end

    // ************************************************************
    // Status choice
    // ************************************************************
    assign pi_bad = pi_illegal(pi_field, ns_pi_enabled, ns_pi_allowed_mask);
    assign conflict = !directives_enabled && (dt_field != 4'h0);

    always_comb begin
        if (conflict) begin
            status = WCD_SC_CONFLICT;
        end else if (pi_bad) begin
            status = WCD_SC_BAD_PI;
        end else if (range_read_only) begin
            status = WCD_SC_READ_ONLY;
        end else begin
            status = WCD_SC_SUCCESS;
        end
    end

    // ************************************************************
    // Acceptance: needs room for job and completion
    // ************************************************************
    assign ok = status == WCD_SC_SUCCESS;
    assign take = cmd_valid && cmd_ready;
    assign out_ready = job_ready && !job_valid;
    assign nxt_cmd_ready = !take && !(cpl_valid && !cpl_ready)
        && (buf_in_ready || (out_valid && out_ready));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmd_ready <= 1'b1;
        end else begin
            cmd_ready <= nxt_cmd_ready;
        end
    end

    // ************************************************************
    // Job buffer
    // ************************************************************
    wcd_skid #(
        .WIDTH($bits(wcd_job_t))
    ) u_buf (
        .clk(clk),
        .rstn(rstn),
        .in_valid(take && ok),
        .in_ready(buf_in_ready),
        .in_data(dec),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_job)
    );

    // ************************************************************
    // Job output valid
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            job_valid <= 1'b0;
        end else if (job_valid) begin
            if (job_ready) begin
                job_valid <= 1'b0;
            end
        end else if (out_valid && job_ready) begin
            job_valid <= 1'b1;
        end
    end

    // ************************************************************
    // Job output data
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            job <= '0;
        end else if (out_valid && out_ready) begin
            job <= out_job;
        end
    end

    // ************************************************************
    // Completion valid
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cpl_valid <= 1'b0;
        end else if (take) begin
            cpl_valid <= 1'b1;
        end else if (cpl_valid && cpl_ready) begin
            cpl_valid <= 1'b0;
        end
    end

    // ************************************************************
    // Completion data
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cpl <= '0;
        end else if (take) begin
            cpl.cmd_id <= 16'(cmd_id);
            cpl.status <= status;
        end
    end

    // Reserved ranges of words twelve and thirteen are never read

endmodule

// ### wcd_decoder_assertions.sv
// Purpose: Checker for the write command decoder
// Assumes: Bound to every wcd_decoder instance
// Notes: Sees top ports only
`timescale 1ns/1ps
module wcd_chk
    import wcd_pkg::*;
#(
    parameter int ID_WIDTH = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [ID_WIDTH-1:0] cmd_id,
    input wire wcd_cmd_t cmd,
    input wire logic ns_pi_enabled,
    input wire logic range_read_only,
    input wire logic directives_enabled,
    input wire logic job_valid,
    input wire logic job_ready,
    input wire wcd_job_t job,
    input wire logic cpl_valid,
    input wire logic cpl_ready,
    input wire wcd_cpl_t cpl
);
    // ****************
    // Properties
    // ****************
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic take = cmd_valid && cmd_ready;
    wire logic no_dt = cmd.dw12[23:20] == 4'h0;

    chk_cpl_after_take: assert property (take |=> cpl_valid && cpl.cmd_id == $past(cmd_id))
        else $error("no completion after take");
    chk_cpl_holds: assert property (cpl_valid && !cpl_ready |=> cpl_valid && $stable(cpl))
        else $error("completion dropped");
    chk_busy_refuse: assert property (cpl_valid |-> !cmd_ready)
        else $error("command taken while completion pending");
    chk_conflict_code: assert property (take && !no_dt && !directives_enabled
        |=> cpl.status == WCD_SC_CONFLICT) else $error("conflict status wrong");
    chk_bad_pi_code: assert property (take && no_dt && !ns_pi_enabled
        && cmd.dw12[29:26] != 4'h0 |=> cpl.status == WCD_SC_BAD_PI) else $error("pi status wrong");
    chk_read_only_code: assert property (take && no_dt && cmd.dw12[29:26] == 4'h0
        && range_read_only |=> cpl.status == WCD_SC_READ_ONLY) else $error("ro status wrong");
    chk_job_holds: assert property (job_valid && !job_ready |=> job_valid && $stable(job))
        else $error("job dropped");
    chk_block_total: assert property (job_valid
        |-> job.block_total == {1'b0, job.block_count_minus_one} + WCD_ONE_17)
        else $error("block total wrong");
    chk_freq_reserved: assert property (job_valid
        |-> job.dataset_hints.freq_reserved == (job.dataset_hints.frequency > 4'h6))
        else $error("reserved frequency flag wrong");
    chk_tag_gated: assert property (job_valid && !job.pi_in_use
        |-> job.initial_reference_tag == 32'h0) else $error("tag without protection");
    cover property (take && cmd.sgl_mode);
    cover property (cpl_valid && cpl.status == WCD_SC_READ_ONLY);
    cover property ((job_valid && !job_ready) [*3]);
endmodule
bind wcd_decoder wcd_chk #(.ID_WIDTH(ID_WIDTH)) chk_u (.clk(clk), .rstn(rstn),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_id(cmd_id), .cmd(cmd),
    .ns_pi_enabled(ns_pi_enabled), .range_read_only(range_read_only),
    .directives_enabled(directives_enabled), .job_valid(job_valid), .job_ready(job_ready),
    .job(job), .cpl_valid(cpl_valid), .cpl_ready(cpl_ready), .cpl(cpl));

// ### wcd_host_model.sv
// Purpose: Consumer of decoded jobs and completions
// Assumes: Mode 0 prompt, 1 random stalls, 2 executor stalled
// Notes: Ready changes only after clock edges
`timescale 1ns/1ps
module wcd_host_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] mode,
    output logic job_ready,
    output logic cpl_ready
);
    // ****************
    // Stall pattern
    // ****************
    logic [15:0] rnd_ff;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rnd_ff <= 16'hACE1;
        end else begin
            rnd_ff <= {rnd_ff[14:0], rnd_ff[15] ^ rnd_ff[13] ^ rnd_ff[12] ^ rnd_ff[10]};
        end
    end
    assign job_ready = (mode == 2'h0) || (mode == 2'h1 && rnd_ff[0]);
    assign cpl_ready = (mode != 2'h1) || rnd_ff[3];
endmodule

// ### test_write_command_decoder.sv
// Purpose: Self-checking bench for the write command decoder
// Assumes: Host model consumes jobs and completions
// Notes: Driver queues expectations, monitor compares
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    num_checks++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("wrong value %s exp %0h got %0h", what, exp, got); \
    end
module test_write_command_decoder
    import wcd_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cmd_valid = 1'b0;
    logic [15:0] cmd_id = 16'h0000;
    wcd_cmd_t cmd = '0;
    wcd_cmd_t c;
    logic pi_en = 1'b0, meta_en = 1'b0, ro = 1'b0, dir_en = 1'b0;
    logic [3:0] pi_mask = 4'h0;
    logic [1:0] mode = 2'h0;
    logic cmd_ready, job_valid, job_ready, cpl_valid, cpl_ready;
    logic [31:0] r;
    logic [31:0] seed = 32'h8C93;
    wcd_job_t job, ej;
    wcd_cpl_t cpl, ec;
    wcd_job_t exp_jobs[$];
    wcd_cpl_t exp_cpls[$];
    int fail_count = 0;
    int num_checks = 0;
    always #5 clk = ~clk;

    wcd_decoder #(.ID_WIDTH(16)) dut_u (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_id(cmd_id), .cmd(cmd), .ns_pi_enabled(pi_en),
        .ns_meta_enabled(meta_en), .ns_pi_allowed_mask(pi_mask), .range_read_only(ro),
        .directives_enabled(dir_en), .job_valid(job_valid), .job_ready(job_ready),
        .job(job), .cpl_valid(cpl_valid), .cpl_ready(cpl_ready), .cpl(cpl));
    wcd_host_model host_u (.clk(clk), .rstn(rstn), .mode(mode), .job_ready(job_ready),
        .cpl_ready(cpl_ready));

    // ****************
    // Models
    // ****************
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic [7:0] exp_status(input wcd_cmd_t k);
        if (k.dw12[23:20] != 4'h0 && !dir_en) return WCD_SC_CONFLICT;
        if (pi_en ? |(k.dw12[29:26] & ~pi_mask) : |k.dw12[29:26]) return WCD_SC_BAD_PI;
        if (ro) return WCD_SC_READ_ONLY;
        return WCD_SC_SUCCESS;
    endfunction
    function automatic wcd_job_t exp_job(input wcd_cmd_t k);
        wcd_job_t j;
        j = '0;
        j.sgl_mode = k.sgl_mode;
        j.meta_in_use = meta_en;
        j.pi_in_use = pi_en;
        j.meta_buffer_pointer = meta_en ? k.meta_buffer_pointer : 64'h0;
        j.prp_entry_1 = k.data_buffer_pointer[63:0];
        j.prp_entry_2 = k.data_buffer_pointer[127:64];
        j.sgl_entry_1 = k.data_buffer_pointer;
        j.first_block_address = {k.dw11, k.dw10};
        j.block_count_minus_one = k.dw12[15:0];
        j.block_total = {1'b0, k.dw12[15:0]} + 17'h00001;
        j.limited_retry = k.dw12[31];
        j.force_media_commit = k.dw12[30];
        j.protection_action_check = k.dw12[29:26];
        j.directive_kind = k.dw12[23:20];
        j.directive_value = k.dw13[31:16];
        j.dataset_hints = {k.dw13[7:4], k.dw13[3:0], k.dw13[3:0] > 4'h6};
        if (pi_en) begin
            j.initial_reference_tag = k.dw14;
            j.app_tag_mask = k.dw15[31:16];
            j.app_tag_value = k.dw15[15:0];
        end
        return j;
    endfunction
    function automatic wcd_job_t cut(input wcd_job_t j, input logic sgl);
        if (sgl) begin
            j.prp_entry_1 = '0;
            j.prp_entry_2 = '0;
        end else begin
            j.sgl_entry_1 = '0;
        end
        return j;
    endfunction

    // ****************
    // Driver and monitor
    // ****************
    task automatic send(input wcd_cmd_t k);
        int n;
        n = 0;
        cmd = k;
        cmd_id = cmd_id + 16'h0001;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 300) begin
            fail_count++;
        end
        exp_cpls.push_back({cmd_id, exp_status(k)});
        if (exp_status(k) == WCD_SC_SUCCESS) exp_jobs.push_back(exp_job(k));
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        @(posedge clk);
        #1;
    endtask
    always @(negedge clk) begin
        if (rstn && cpl_valid === 1'b1 && cpl_ready === 1'b1) begin
            ec = exp_cpls.pop_front();
            `CHK("completion", ec, cpl)
        end
        if (rstn && job_valid === 1'b1 && job_ready === 1'b1) begin
            ej = exp_jobs.pop_front();
            `CHK("job", cut(ej, ej.sgl_mode), cut(job, ej.sgl_mode))
        end
    end

    task automatic tally_and_finish();
        if (fail_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200000;
        fail_count++;
        tally_and_finish();
    end

    // ****************
    // Scenarios
    // ****************
    initial begin
        repeat (2) @(posedge clk);
        #1;
        rstn = 1'b1;
        for (int i = 0; i < 32; i++) begin
            r = rnd();
            {pi_mask, dir_en, meta_en, pi_en} = r[6:0];
            ro = r[9:7] == 3'h0;
            mode = {1'b0, r[10]};
            c.sgl_mode = r[11];
            c.meta_buffer_pointer = {rnd(), rnd()};
            c.data_buffer_pointer = {rnd(), rnd(), rnd(), rnd()};
            c.dw10 = rnd();
            c.dw11 = rnd();
            c.dw14 = rnd();
            c.dw15 = rnd();
            c.dw12 = rnd();
            c.dw12[23:20] = r[12] ? r[16:13] : 4'h0;
            c.dw12[29:26] = r[17] ? r[21:18] : 4'h0;
            c.dw12[15:0] = i == 0 ? 16'hFFFF : (i == 1 ? 16'h0000 : c.dw12[15:0]);
            c.dw13 = rnd();
            c.dw13[5:0] = {i[4:3], i[3:0]};
            send(c);
        end
        mode = 2'h0;
        repeat (10) @(posedge clk);
        #1;
        {mode, pi_en, ro, dir_en} = 5'h11;
        c.dw12[29:20] = 10'h000;
        send(c);
        send(c);
        repeat (3) @(posedge clk);
        #1;
        `CHK("full buffer ready", 1'b0, cmd_ready)
        mode = 2'h0;
        repeat (20) @(posedge clk);
        `CHK("pending notes", 0, exp_jobs.size() + exp_cpls.size())
        tally_and_finish();
    end
endmodule
